// ==== spim_top.sv ====
// Interrupt mask, sticky status and request logic of the serial port
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module spim_top
  import spim_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Register bus
  input  wire spim_pkg::spim_req_t bus_req,
  output logic [31:0]            rd_data_q,
  // Port state
  input  wire logic [3:0]        op_mode,
  input  wire spim_pkg::spim_src_t src,
  // Interrupt request
  output logic                   irq_q
);
  import spim_pkg::*;

  logic        spi_mode;
  logic [31:0] layout;
  logic        wr_enable;
  logic        wr_clear;
  logic        wr_status;
  logic [31:0] mask_q;
  logic [31:0] sticky_q;
  logic [31:0] sticky_d;
  logic [31:0] sticky_clr;
  logic [31:0] status_view;
  logic [31:0] pending;

  // Bit map of the sources, one position per source in every register:
  // receive ready at 0, transmit holding free at 1
  // break received at 2
  // overrun at 5, framing at 6, parity at 7
  // buffer sources at 3, 4, 11 and 12 in every mode
  // transmitter drained at 9, receive time-out at 8
  // repeat limit at 10, not acknowledged at 13
  // clear-to-send change at 19, Manchester error at 24
  // The same masks feed enable, clear, mask read and status, so a
  // position can never drift between the four registers.

  // Layout follows the operating mode field
  assign spi_mode = (op_mode == MODE_SPI_MASTER) ||
                    (op_mode == MODE_SPI_SLAVE);
  // SPI drops the character-only sources; bit 10 keeps its slot
  assign layout   = spi_mode ? SPI_LAYOUT : CHAR_LAYOUT;

  // Address decode of write strobes
  assign wr_enable = bus_req.wr && (bus_req.addr == ADDR_ENABLE_SET);
  assign wr_clear  = bus_req.wr && (bus_req.addr == ADDR_ENABLE_CLEAR);
  assign wr_status = bus_req.wr && (bus_req.addr == ADDR_EVENT_STATUS);

  // Mask bits; writes only touch the bits of the live layout
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mask_q <= MASK_RESET;
    else if (wr_enable)
      mask_q <= mask_q | (bus_req.wdata & layout);
    else if (wr_clear)
      mask_q <= mask_q & ~(bus_req.wdata & layout);
  end

  // Sticky clear: write-one to status, or the status reset command
  always_comb
  begin
    sticky_clr = bus_req.wdata & {32{wr_status}};
    if (src.status_reset_command)
      sticky_clr = sticky_clr | STATUS_RESET_BITS;
  end

  // A new event beats a clear in the same cycle
  assign sticky_d = (sticky_q & ~sticky_clr) |
                    (src.set & STICKY_BITS);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sticky_q <= STATUS_RESET;
    else
      sticky_q <= sticky_d;
  end

  // Level sources pass straight; sticky ones come from the hold register
  assign status_view = (src.level & ~STICKY_BITS) | sticky_q;
  assign pending     = status_view & mask_q & layout;

  // Registered request keeps the output glitch free, one cycle late
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= |pending;
  end

  // Read data valid the cycle after the strobe; write-only reads zero
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rd_data_q <= READ_ZERO;
    else if (bus_req.rd && (bus_req.addr == ADDR_MASK_STATE))
      rd_data_q <= mask_q & layout;
    else if (bus_req.rd && (bus_req.addr == ADDR_EVENT_STATUS))
      rd_data_q <= status_view & layout;
    else
      rd_data_q <= READ_ZERO;
  end

  // Checks on the mask, the sticky flags and the request
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ENABLE_SETS: assert property (
    wr_enable |=> ((mask_q & $past(bus_req.wdata & layout))
                   == $past(bus_req.wdata & layout)))
    else $error("enable write did not set mask bits");

  AST_ENABLE_KEEPS: assert property (
    wr_enable |=> ((mask_q & ~$past(bus_req.wdata & layout))
                   == ($past(mask_q) & ~$past(bus_req.wdata & layout))))
    else $error("enable write changed unwritten mask bits");

  AST_CLEAR_CLEARS: assert property (
    wr_clear |=> ((mask_q & $past(bus_req.wdata & layout)) == 32'h0)
              && ((mask_q & ~$past(bus_req.wdata & layout))
                  == ($past(mask_q) & ~$past(bus_req.wdata & layout))))
    else $error("disable write misbehaved");

  AST_MASK_READ: assert property (
    (bus_req.rd && bus_req.addr == ADDR_MASK_STATE)
      |=> rd_data_q == $past(mask_q & layout))
    else $error("mask read does not match mask state");

  AST_RX_TX_POS: assert property (
    (wr_enable && !spi_mode && bus_req.wdata[BIT_RX_CHAR_READY]
     && bus_req.wdata[BIT_TX_HOLDING_FREE])
      |=> mask_q[BIT_RX_CHAR_READY] && mask_q[BIT_TX_HOLDING_FREE])
    else $error("bits 0 and 1 not enabled in character mode");

  AST_BREAK_POS: assert property (
    (wr_enable && !spi_mode && bus_req.wdata[BIT_BREAK_RECEIVED])
      |=> mask_q[BIT_BREAK_RECEIVED])
    else $error("break bit not enabled in character mode");

  AST_ERROR_POS: assert property (
    (wr_enable && !spi_mode && bus_req.wdata[BIT_OVERRUN_ERROR]
     && bus_req.wdata[BIT_FRAMING_ERROR] && bus_req.wdata[BIT_PARITY_ERROR])
      |=> mask_q[BIT_OVERRUN_ERROR] && mask_q[BIT_FRAMING_ERROR]
          && mask_q[BIT_PARITY_ERROR])
    else $error("error bits not enabled in character mode");

  AST_BUFFER_ALL_MODES: assert property (
    (wr_enable && bus_req.wdata[BIT_RX_COUNT_DONE]
     && bus_req.wdata[BIT_TX_COUNT_DONE]
     && bus_req.wdata[BIT_TX_BUFFERS_DRAINED]
     && bus_req.wdata[BIT_RX_BUFFERS_FILLED])
      |=> mask_q[BIT_RX_COUNT_DONE] && mask_q[BIT_TX_COUNT_DONE]
          && mask_q[BIT_TX_BUFFERS_DRAINED] && mask_q[BIT_RX_BUFFERS_FILLED])
    else $error("buffer bits not enabled in some mode");

  AST_DRAIN_TIMEOUT: assert property (
    (wr_enable && bus_req.wdata[BIT_TRANSMITTER_DRAIN]
     && (spi_mode || bus_req.wdata[BIT_RX_TIMEOUT]))
      |=> mask_q[BIT_TRANSMITTER_DRAIN]
          && ($past(spi_mode) || mask_q[BIT_RX_TIMEOUT]))
    else $error("drain or time-out bit not enabled");

  AST_REPEAT_NOT_ACKNOWLEDGED: assert property (
    (wr_enable && !spi_mode && bus_req.wdata[BIT_REPEAT_LIMIT]
     && bus_req.wdata[BIT_NOT_ACKNOWLEDGED])
      |=> mask_q[BIT_REPEAT_LIMIT] && mask_q[BIT_NOT_ACKNOWLEDGED])
    else $error("bits 10 and 13 not enabled in character mode");

  AST_CTS_MANCH: assert property (
    (wr_enable && !spi_mode && bus_req.wdata[BIT_CLEAR_TO_SEND_CHG]
     && bus_req.wdata[BIT_MANCHESTER_ERROR])
      |=> mask_q[BIT_CLEAR_TO_SEND_CHG] && mask_q[BIT_MANCHESTER_ERROR])
    else $error("bits 19 and 24 not enabled in character mode");

  AST_SPI_HIDES_CHAR: assert property (
    (bus_req.rd && bus_req.addr == ADDR_MASK_STATE && spi_mode)
      |=> ((rd_data_q & CHAR_ONLY) == 32'h0)
          && (rd_data_q[BIT_SPI_UNDERRUN] == $past(mask_q[BIT_SPI_UNDERRUN])))
    else $error("character-only bits visible in SPI mode");

  AST_MODE_SELECT: assert property (
    (wr_enable && (op_mode != MODE_SPI_MASTER)
     && (op_mode != MODE_SPI_SLAVE) && bus_req.wdata[BIT_FRAMING_ERROR])
      |=> mask_q[BIT_FRAMING_ERROR])
    else $error("non-SPI mode code did not give character layout");

  AST_SPI_WRITE_IGNORES: assert property (
    (wr_enable && spi_mode && !mask_q[BIT_PARITY_ERROR])
      |=> !mask_q[BIT_PARITY_ERROR])
    else $error("SPI-mode write touched a character-only bit");

  AST_STICKY_HOLDS: assert property (
    (sticky_q[BIT_OVERRUN_ERROR] && !src.status_reset_command
     && !(wr_status && bus_req.wdata[BIT_OVERRUN_ERROR]))
      |=> sticky_q[BIT_OVERRUN_ERROR])
    else $error("overrun flag dropped without a clear");

  AST_STATUS_RESET: assert property (
    (src.status_reset_command && !src.set[BIT_OVERRUN_ERROR])
      |=> !sticky_q[BIT_OVERRUN_ERROR])
    else $error("status reset command left overrun set");

  AST_SET_WINS: assert property (
    src.set[BIT_PARITY_ERROR] |=> sticky_q[BIT_PARITY_ERROR])
    else $error("parity event lost");

  AST_IRQ_FOLLOWS: assert property (
    irq_q == $past(|(status_view & mask_q & layout)))
    else $error("interrupt does not follow masked status");

  AST_IRQ_DROPS: assert property (
    (mask_q == 32'h0) [*2] |-> !irq_q)
    else $error("interrupt high with all sources masked");

  AST_RESET_CLEARS: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    rst |=> (mask_q == MASK_RESET) && !irq_q)
    else $error("mask not clear after reset");

  AST_RESET_STICKY: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    rst |=> (sticky_q == STATUS_RESET) && (rd_data_q == READ_ZERO))
    else $error("sticky flags or read data not clear after reset");

  // Writes of all zeros must be harmless on both write-only registers
  AST_ENABLE_ZERO: assert property (
    (wr_enable && (bus_req.wdata == 32'h0)) |=> $stable(mask_q))
    else $error("enable write of zero changed the mask");

  AST_CLEAR_ZERO: assert property (
    (wr_clear && (bus_req.wdata == 32'h0)) |=> $stable(mask_q))
    else $error("disable write of zero changed the mask");

  // Only the two write-only registers may move the mask
  AST_MASK_QUIET: assert property (
    (!wr_enable && !wr_clear) |=> $stable(mask_q))
    else $error("mask changed without an enable or disable write");

  // Reads of any other address return zero, idle cycles too
  AST_READ_OTHER_ZERO: assert property (
    (bus_req.rd && (bus_req.addr != ADDR_MASK_STATE)
     && (bus_req.addr != ADDR_EVENT_STATUS))
      |=> rd_data_q == READ_ZERO)
    else $error("unmapped read returned data");

  AST_READ_IDLE_ZERO: assert property (
    !bus_req.rd |=> rd_data_q == READ_ZERO)
    else $error("read data stood without a read strobe");

  AST_MASK_READ_CHAR: assert property (
    (bus_req.rd && (bus_req.addr == ADDR_MASK_STATE) && !spi_mode)
      |=> rd_data_q == $past(mask_q & CHAR_LAYOUT))
    else $error("character-mode mask read lost a source");

  // In SPI mode bit 10 belongs to the underrun source
  AST_UNDERRUN_POS: assert property (
    (wr_enable && spi_mode && bus_req.wdata[BIT_SPI_UNDERRUN])
      |=> mask_q[BIT_SPI_UNDERRUN])
    else $error("underrun bit not enabled in SPI mode");

  AST_SPI_CLEAR_IGNORES: assert property (
    (wr_clear && spi_mode && mask_q[BIT_FRAMING_ERROR])
      |=> mask_q[BIT_FRAMING_ERROR])
    else $error("SPI-mode disable touched a character-only bit");

  AST_SPI_SILENT: assert property (
    (spi_mode && !(|(status_view & mask_q & SPI_LAYOUT))) |=> !irq_q)
    else $error("character-only source raised the request in SPI mode");

  // Set beats clear; write-one clear works on its own
  AST_SET_BEATS_RESET: assert property (
    (src.set[BIT_OVERRUN_ERROR] && src.status_reset_command)
      |=> sticky_q[BIT_OVERRUN_ERROR])
    else $error("overrun event lost to a status reset");

  AST_STATUS_WRITE_CLEARS: assert property (
    (wr_status && bus_req.wdata[BIT_PARITY_ERROR]
     && !src.set[BIT_PARITY_ERROR])
      |=> !sticky_q[BIT_PARITY_ERROR])
    else $error("write-one did not clear the parity flag");

  // Level sources reach the request without being held
  AST_LEVEL_RAISES: assert property (
    (src.level[BIT_TX_BUFFERS_DRAINED] && mask_q[BIT_TX_BUFFERS_DRAINED])
      |=> irq_q)
    else $error("enabled buffer level did not raise the request");

  AST_IRQ_LOW_IDLE: assert property (
    !(|(status_view & mask_q & layout)) |=> !irq_q)
    else $error("request high with nothing pending");

  // Main scenarios
  COV_SPI_IRQ: cover property (spi_mode && $rose(irq_q));
  COV_CHAR_IRQ: cover property (!spi_mode && mask_q[BIT_PARITY_ERROR]
                                 ##1 $rose(irq_q));
  COV_SET_CLEAR_CLASH: cover property (src.status_reset_command
                                       && src.set[BIT_OVERRUN_ERROR]);
  COV_ENABLE_THEN_DISABLE: cover property (wr_enable ##[1:4] wr_clear);
  COV_STATUS_CLEAR: cover property (wr_status && (sticky_q != 32'h0)
                                    ##1 (sticky_q == 32'h0));

endmodule : spim_top

// ==== spim_pkg.sv ====
// Package of constants and types for the serial port interrupt mask block
package spim_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_ENABLE_SET   = 32'h4002_4008;
  localparam logic [31:0] ADDR_ENABLE_CLEAR = 32'h4002_400c;
  localparam logic [31:0] ADDR_MASK_STATE   = 32'h4002_4010;
  localparam logic [31:0] ADDR_EVENT_STATUS = 32'h4002_4030;

  // Source bit positions, shared by enable, clear, mask and status
  localparam int BIT_RX_CHAR_READY      = 0;
  localparam int BIT_TX_HOLDING_FREE    = 1;
  localparam int BIT_BREAK_RECEIVED     = 2;
  localparam int BIT_RX_COUNT_DONE      = 3;
  localparam int BIT_TX_COUNT_DONE      = 4;
  localparam int BIT_OVERRUN_ERROR      = 5;
  localparam int BIT_FRAMING_ERROR      = 6;
  localparam int BIT_PARITY_ERROR       = 7;
  localparam int BIT_RX_TIMEOUT         = 8;
  localparam int BIT_TRANSMITTER_DRAIN  = 9;
  localparam int BIT_REPEAT_LIMIT       = 10;
  localparam int BIT_SPI_UNDERRUN       = 10;
  localparam int BIT_TX_BUFFERS_DRAINED = 11;
  localparam int BIT_RX_BUFFERS_FILLED  = 12;
  localparam int BIT_NOT_ACKNOWLEDGED   = 13;
  localparam int BIT_CLEAR_TO_SEND_CHG  = 19;
  localparam int BIT_MANCHESTER_ERROR   = 24;

  // Bits that do something in SPI master or slave mode
  localparam logic [31:0] SPI_LAYOUT =
    (32'h1 << BIT_RX_CHAR_READY) | (32'h1 << BIT_TX_HOLDING_FREE) |
    (32'h1 << BIT_RX_COUNT_DONE) | (32'h1 << BIT_TX_COUNT_DONE) |
    (32'h1 << BIT_OVERRUN_ERROR) | (32'h1 << BIT_TRANSMITTER_DRAIN) |
    (32'h1 << BIT_SPI_UNDERRUN) | (32'h1 << BIT_TX_BUFFERS_DRAINED) |
    (32'h1 << BIT_RX_BUFFERS_FILLED);

  // Bits that exist only in the character modes
  localparam logic [31:0] CHAR_ONLY =
    (32'h1 << BIT_BREAK_RECEIVED) | (32'h1 << BIT_FRAMING_ERROR) |
    (32'h1 << BIT_PARITY_ERROR) | (32'h1 << BIT_RX_TIMEOUT) |
    (32'h1 << BIT_NOT_ACKNOWLEDGED) | (32'h1 << BIT_CLEAR_TO_SEND_CHG) |
    (32'h1 << BIT_MANCHESTER_ERROR);

  localparam logic [31:0] CHAR_LAYOUT = SPI_LAYOUT | CHAR_ONLY;

  // Sources held sticky inside the block until cleared
  localparam logic [31:0] STICKY_BITS =
    (32'h1 << BIT_BREAK_RECEIVED) | (32'h1 << BIT_OVERRUN_ERROR) |
    (32'h1 << BIT_FRAMING_ERROR) | (32'h1 << BIT_PARITY_ERROR) |
    (32'h1 << BIT_REPEAT_LIMIT) | (32'h1 << BIT_NOT_ACKNOWLEDGED) |
    (32'h1 << BIT_CLEAR_TO_SEND_CHG) | (32'h1 << BIT_MANCHESTER_ERROR);

  // Error flags that the status reset command clears
  localparam logic [31:0] STATUS_RESET_BITS =
    (32'h1 << BIT_BREAK_RECEIVED) | (32'h1 << BIT_OVERRUN_ERROR) |
    (32'h1 << BIT_FRAMING_ERROR) | (32'h1 << BIT_PARITY_ERROR) |
    (32'h1 << BIT_SPI_UNDERRUN) | (32'h1 << BIT_MANCHESTER_ERROR);

  // Reset values
  localparam logic [31:0] MASK_RESET   = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

  // Operating mode codes that select the SPI layout
  localparam logic [3:0] MODE_SPI_MASTER = 4'he;
  localparam logic [3:0] MODE_SPI_SLAVE  = 4'hf;

  // Register bus request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } spim_req_t;

  // Interrupt sources from the rest of the port
  typedef struct packed {
    logic [31:0] level;
    logic [31:0] set;
    logic        status_reset_command;
  } spim_src_t;

endpackage : spim_pkg

// ==== spim_src_model.sv ====
// Far-side model of the port sources feeding the mask block
`timescale 1ns/1ps
module spim_src_model
  import spim_pkg::*;
(
  // Clock
  input  wire logic           sys_clk,
  // Sources toward the mask block
  output spim_pkg::spim_src_t src
);
  // Quiet sources until the bench asks for activity
  initial
  begin
    src = '0;
  end

  // Level sources follow the port state, held until changed
  task automatic set_level(input int b, input logic v);
  begin
    @(posedge sys_clk);
    src.level[b] <= v;
  end
  endtask : set_level

  // One-cycle event; the block must keep it sticky
  task automatic pulse_event(input int b);
  begin
    @(posedge sys_clk);
    src.set[b] <= 1'b1;
    @(posedge sys_clk);
    src.set[b] <= 1'b0;
  end
  endtask : pulse_event

  // Software status reset command, one cycle
  task automatic pulse_reset();
  begin
    @(posedge sys_clk);
    src.status_reset_command <= 1'b1;
    @(posedge sys_clk);
    src.status_reset_command <= 1'b0;
  end
  endtask : pulse_reset
endmodule : spim_src_model

// ==== test_spim_top.sv ====
// Self-checking testbench of the serial port interrupt mask block
`timescale 1ns/1ps
module test_spim_top;
  import spim_pkg::*;
  localparam int CYC_LIMIT = 6000;
  logic        sys_clk;
  logic        rst;
  spim_req_t   bus_req;
  logic [31:0] rd_data_q;
  logic [3:0]  op_mode;
  spim_src_t   src;
  logic        irq_q;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc_cnt = 0;

  spim_top spim_top_inst (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .rd_data_q(rd_data_q), .op_mode(op_mode), .src(src), .irq_q(irq_q));
  spim_src_model spim_src_model_inst (.sys_clk(sys_clk), .src(src));

  // Clock, 8 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Hang guard, counts as a mismatch
  always @(posedge sys_clk)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == CYC_LIMIT)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
  begin
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask : check

  // Expected layout derived from the mode field
  function automatic logic [31:0] lay(input logic [3:0] m);
    return (m == MODE_SPI_MASTER || m == MODE_SPI_SLAVE) ?
           SPI_LAYOUT : CHAR_LAYOUT;
  endfunction : lay

  // One-cycle write strobe, released on the following edge
  task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
  begin
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  end
  endtask : bus_wr

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
  begin
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = rd_data_q;
  end
  endtask : bus_rd

  task automatic rd_is(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
  begin
    bus_rd(a, v);
    check("read data", v, exp);
  end
  endtask : rd_is

  // Request is registered one cycle behind its cause
  task automatic irq_is(input logic exp);
  begin
    @(posedge sys_clk);
    #1;
    check("irq", {31'h0, irq_q}, {31'h0, exp});
  end
  endtask : irq_is

  task automatic mode(input logic [3:0] m);
  begin
    @(posedge sys_clk);
    op_mode <= m;
    bus_wr(ADDR_ENABLE_CLEAR, 32'hffff_ffff);
  end
  endtask : mode

  task automatic t_reset();
  begin
    rd_is(ADDR_MASK_STATE, MASK_RESET);
    check("irq idle", {31'h0, irq_q}, 32'h0);
    rd_is(ADDR_ENABLE_SET, READ_ZERO);
    rd_is(32'h4002_4020, READ_ZERO);
  end
  endtask : t_reset

  // Walk every position through set then read
  task automatic t_bits();
  begin
    for (int i = 0; i < 32; i++)
    begin
      mode(4'h0);
      bus_wr(ADDR_ENABLE_SET, 32'h1 << i);
      rd_is(ADDR_MASK_STATE, (32'h1 << i) & CHAR_LAYOUT);
    end
  end
  endtask : t_bits

  // Zeros must leave bits alone; strobes one idle cycle apart
  task automatic t_setclr();
  begin
    mode(4'h0);
    bus_wr(ADDR_ENABLE_SET, 32'h0000_0021);
    bus_wr(ADDR_ENABLE_SET, 32'h0000_0000);
    rd_is(ADDR_MASK_STATE, 32'h0000_0021);
    bus_wr(ADDR_ENABLE_SET, 32'h0000_0080);
    bus_wr(ADDR_ENABLE_CLEAR, 32'h0000_0020);
    bus_wr(ADDR_ENABLE_CLEAR, 32'h0000_0000);
    rd_is(ADDR_MASK_STATE, 32'h0000_0081);
  end
  endtask : t_setclr

  task automatic t_modes();
    logic [3:0] ms[5] = '{4'h0, 4'hd, 4'he, 4'hf, 4'h7};
  begin
    foreach (ms[k])
    begin
      mode(ms[k]);
      bus_wr(ADDR_ENABLE_SET, 32'hffff_ffff);
      rd_is(ADDR_MASK_STATE, lay(ms[k]));
    end
  end
  endtask : t_modes

  task automatic t_irq();
  begin
    mode(4'h0);
    spim_src_model_inst.pulse_event(BIT_OVERRUN_ERROR);
    irq_is(1'b0);
    bus_wr(ADDR_ENABLE_SET, 32'h1 << BIT_OVERRUN_ERROR);
    irq_is(1'b1);
    repeat (4) @(posedge sys_clk);
    irq_is(1'b1);
    spim_src_model_inst.pulse_reset();
    irq_is(1'b0);
    spim_src_model_inst.set_level(BIT_TX_BUFFERS_DRAINED, 1'b1);
    bus_wr(ADDR_ENABLE_SET, 32'h1 << BIT_TX_BUFFERS_DRAINED);
    irq_is(1'b1);
    bus_wr(ADDR_ENABLE_CLEAR, 32'h1 << BIT_TX_BUFFERS_DRAINED);
    irq_is(1'b0);
    spim_src_model_inst.set_level(BIT_TX_BUFFERS_DRAINED, 1'b0);
  end
  endtask : t_irq

  // Underrun owns bit 10; break has no function here
  task automatic t_spi();
  begin
    mode(MODE_SPI_MASTER);
    spim_src_model_inst.pulse_event(BIT_SPI_UNDERRUN);
    bus_wr(ADDR_ENABLE_SET, 32'h1 << BIT_SPI_UNDERRUN);
    irq_is(1'b1);
    spim_src_model_inst.pulse_reset();
    irq_is(1'b0);
    bus_wr(ADDR_ENABLE_SET, 32'h1 << BIT_BREAK_RECEIVED);
    spim_src_model_inst.pulse_event(BIT_BREAK_RECEIVED);
    irq_is(1'b0);
    rd_is(ADDR_MASK_STATE, 32'h1 << BIT_SPI_UNDERRUN);
    spim_src_model_inst.pulse_reset();
  end
  endtask : t_spi

  // Status register: sticky event, then write-one clear
  task automatic t_status();
  begin
    mode(4'h0);
    spim_src_model_inst.pulse_event(BIT_PARITY_ERROR);
    rd_is(ADDR_EVENT_STATUS, 32'h1 << BIT_PARITY_ERROR);
    bus_wr(ADDR_EVENT_STATUS, 32'h1 << BIT_PARITY_ERROR);
    rd_is(ADDR_EVENT_STATUS, READ_ZERO);
  end
  endtask : t_status

  // Mid-run reset must drop every mask bit
  task automatic t_rerst();
  begin
    mode(4'h0);
    bus_wr(ADDR_ENABLE_SET, 32'hffff_ffff);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_is(ADDR_MASK_STATE, MASK_RESET);
  end
  endtask : t_rerst

  // Main sequence
  initial
  begin
    rst = 1'b1;
    bus_req = '0;
    op_mode = 4'h0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_bits();
    t_setclr();
    t_modes();
    t_irq();
    t_spi();
    t_status();
    t_rerst();
    give_verdict();
  end
endmodule : test_spim_top
